// File: hw/dds_pkg.sv
package dds_pkg;

  // Frame and code widths
  localparam int WORD_W = 16;
  localparam int CODE_W = 8;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10;

  // Field positions inside the serial word
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int MODE_HI = 13;
  localparam int MODE_LO = 12;
  localparam int DATA_HI = 11;
  localparam int DATA_LO = 4;

  // Channel address codes
  localparam logic [1:0] ADDR_CHAN_A = 2'h0;
  localparam logic [1:0] ADDR_CHAN_B = 2'h1;

  // Operating modes carried in the word
  localparam logic [1:0] MODE_WRITE_ONLY = 2'h0;
  localparam logic [1:0] MODE_WRITE_UPDATE = 2'h1;
  localparam logic [1:0] MODE_WRITE_ALL = 2'h2;
  localparam logic [1:0] MODE_POWER = 2'h3;

  // Power-down terminations, chosen by the address field in power mode
  localparam logic [1:0] TERM_NONE = 2'h0;
  localparam logic [1:0] TERM_LOW_R = 2'h1;
  localparam logic [1:0] TERM_HIGH_R = 2'h2;
  localparam logic [1:0] TERM_OPEN = 2'h3;

  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [1:0] TERM_RST = 2'h0;

  // Fastest serial clock the link accepts, and system clock period
  localparam int SCLK_MIN_PERIOD_NS = 25;
  localparam int SYS_PERIOD_NS = 50;

  // Sequencer states, Gray along idle, decode, apply
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_APPLY = 2'b11
  } dds_state_t;

endpackage

// File: hw/dds_chan_if.sv
`timescale 1ns/100ps
interface dds_chan_if;
  import dds_pkg::*;
  // Load the input latch with data
  logic load;
  // Move the latched code to the output
  logic update;
  // Code offered for loading
  logic [CODE_W-1:0] data;
  // Code driving the channel output
  logic [CODE_W-1:0] code;

  modport ctrl (output load, output update, output data, input code);
  modport chan (input load, input update, input data, output code);
endinterface

// File: hw/dds_chan.sv
`timescale 1ns/100ps
module dds_chan
  import dds_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control from the sequencer
  dds_chan_if.chan cif
);

  // Input latch, held until an update
  logic [CODE_W-1:0] hold_r;
  // Output code register
  logic [CODE_W-1:0] code_r;

  // Input latch loads on request
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hold_r <= CODE_RST;
    end
    else if (cif.load)
    begin
      hold_r <= cif.data;
    end
  end

  // Output takes the freshest code; zero from reset until first update
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      code_r <= CODE_RST;
    end
    else if (cif.update)
    begin
      code_r <= cif.load ? cif.data : hold_r;
    end
  end

  assign cif.code = code_r;

endmodule

// File: hw/dds_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Shift data in on falling serial clock
// - Shifter enabled only while frame sync low
// - Sixteenth falling edge applies the word
// - Early sync rise discards the partial word
// - Word holds select, mode, power, data
// - Mode bits choose both or addressed channel
// - Each channel keeps an 8-bit code
// - Outputs stay zero until first write that updates them
// - Power-down with three output terminations
module dds_top
  import dds_pkg::*;
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link pins
  input wire logic link_sclk,
  input wire logic sync_n,
  input wire logic din,
  // Channel codes
  output logic [CODE_W-1:0] channel_a_output,
  output logic [CODE_W-1:0] channel_b_output,
  // Power state
  output logic power_down,
  output logic [1:0] pd_term,
  // Status
  output logic word_applied
);

  // Link clock domain, run by the host's serial clock
  // Only the toggle and the held word leave this domain

  // Falling-edge count within the frame
  logic [CNT_W-1:0] edge_cnt_r;
  // Serial shift register
  logic [WORD_W-1:0] shift_r;
  // Completed word, stable between frames
  logic [WORD_W-1:0] word_r;
  // Toggles once per completed frame
  logic word_tgl_r;
  // Next shift contents
  logic [WORD_W-1:0] shift_nxt;

  // Newest bit enters at the bottom; the top bit arrives first
  assign shift_nxt = {shift_r[WORD_W-2:0], din};

  // Edge counter; high sync clears it, so an early rise drops the frame
  // Reset clears it too, as sync_n may give no edge at power-up
  // Saturates at sixteen, so later edges in the frame change nothing
  always_ff @(negedge link_sclk or posedge sync_n or posedge rst)
  begin
    if (sync_n || rst)
    begin
      edge_cnt_r <= '0;
    end
    else if (edge_cnt_r != FRAME_EDGES)
    begin
      edge_cnt_r <= edge_cnt_r + CNT_W'(1);
    end
  end

  // Shift register, only moving while the frame is open and short of full
  // Bits past the sixteenth are dropped until sync rises
  always_ff @(negedge link_sclk or posedge rst)
  begin
    if (rst)
    begin
      shift_r <= WORD_RST;
    end
    else if (!sync_n && edge_cnt_r != FRAME_EDGES)
    begin
      shift_r <= shift_nxt;
    end
  end

  // Capture the word on the sixteenth edge and flag it across
  // word_r then holds still for the system side to copy
  always_ff @(negedge link_sclk or posedge rst)
  begin
    if (rst)
    begin
      word_r <= WORD_RST;
      word_tgl_r <= 1'b0;
    end
    else if (!sync_n && edge_cnt_r == FRAME_EDGES - CNT_W'(1))
    begin
      word_r <= shift_nxt;
      word_tgl_r <= ~word_tgl_r;
    end
  end

  // System clock domain; everything below runs on sys_clk
  // Link signals enter through the toggle synchroniser and the event-gated word_r copy

  // First synchroniser stage, may go metastable
  logic tgl_s1_r;
  // Second stage, the only reader of the first
  logic tgl_s2_r;
  // Previous settled value, for edge detection
  logic tgl_s3_r;
  // New-word event in system domain
  logic word_evt;
  // Word copied from the link side
  logic [WORD_W-1:0] cmd_r;
  // Sequencer state
  dds_state_t state_r;
  // Next state from the sequencer logic
  dds_state_t state_nxt;
  // Address field, or termination in power mode
  logic [1:0] addr_f;
  // Operating mode field
  logic [1:0] mode_f;
  // Channel code field
  logic [CODE_W-1:0] data_f;
  // Powered-down flag
  logic power_down_r;
  // Chosen output termination
  logic [1:0] pd_term_r;
  // Apply pulse register
  logic applied_r;

  // Two flops, then a third for edge detection
  // A toggle crosses safely where a one-cycle pulse could be lost
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end
    else
    begin
      tgl_s1_r <= word_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign word_evt = tgl_s2_r ^ tgl_s3_r;

  // Copy the word once the event has settled; word_r is quiet by then
  // Frames end at least eight sys_clk apart, so the copy never tears
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cmd_r <= WORD_RST;
    end
    else if (word_evt)
    begin
      cmd_r <= word_r;
    end
  end

  // Field split of the copied word
  // The low four bits of the word are not used
  assign addr_f = cmd_r[ADDR_HI:ADDR_LO];
  assign mode_f = cmd_r[MODE_HI:MODE_LO];
  assign data_f = cmd_r[DATA_HI:DATA_LO];

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        // Wait for a settled new word
        if (word_evt)
        begin
          state_nxt = ST_DECODE;
        end
      end
      ST_DECODE:
      begin
        // Fields settle from the copied word
        state_nxt = ST_APPLY;
      end
      ST_APPLY:
      begin
        // Strobes fire during this one cycle
        state_nxt = ST_IDLE;
      end
      default:
      begin
        // Recover from an illegal code
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Channel control buses
  dds_chan_if chan_a_if ();
  dds_chan_if chan_b_if ();

  // High for the one apply cycle
  logic apply;
  // Channel A addressed or broadcast
  logic sel_a;
  // Channel B addressed or broadcast
  logic sel_b;
  // Word carries a code, not a power setting
  logic data_mode;

  assign apply = (state_r == ST_APPLY);
  assign data_mode = (mode_f != MODE_POWER);
  assign sel_a = (mode_f == MODE_WRITE_ALL) || (addr_f == ADDR_CHAN_A);
  assign sel_b = (mode_f == MODE_WRITE_ALL) || (addr_f == ADDR_CHAN_B);

  // Load addressed latches; update per mode
  always_comb
  begin
    // Defaults: code offered, loads from select, updates low
    chan_a_if.data = data_f;
    chan_b_if.data = data_f;
    chan_a_if.load = apply && data_mode && sel_a;
    chan_b_if.load = apply && data_mode && sel_b;
    chan_a_if.update = 1'b0;
    chan_b_if.update = 1'b0;
    if (apply && mode_f == MODE_WRITE_UPDATE)
    begin
      // Addressed channel takes the code at once
      chan_a_if.update = sel_a;
      chan_b_if.update = sel_b;
    end
    else if (apply && mode_f == MODE_WRITE_ALL)
    begin
      // Broadcast write moves both outputs together
      chan_a_if.update = 1'b1;
      chan_b_if.update = 1'b1;
    end
  end

  // Channel A
  dds_chan u_chan_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .cif(chan_a_if.chan)
  );

  // Channel B
  dds_chan u_chan_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .cif(chan_b_if.chan)
  );

  // Power-down state; address field picks termination, none resumes
  // Channel codes are kept through power-down
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      power_down_r <= 1'b0;
      pd_term_r <= TERM_RST;
    end
    else if (apply && !data_mode)
    begin
      power_down_r <= (addr_f != TERM_NONE);
      pd_term_r <= addr_f;
    end
  end

  // One-cycle pulse when a word takes effect
  // Rises at the same edge as the outputs take the new word
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      applied_r <= 1'b0;
    end
    else
    begin
      applied_r <= apply;
    end
  end

  // Outputs
  // All come straight from flip-flops
  assign channel_a_output = chan_a_if.code;
  assign channel_b_output = chan_b_if.code;
  assign power_down = power_down_r;
  assign pd_term = pd_term_r;
  assign word_applied = applied_r;

endmodule

// File: tb/dds_asserts.sv
`timescale 1ns/100ps
// Port checks of the channel, power and status outputs
module dds_asserts
  import dds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sync_n,
  input wire logic [CODE_W-1:0] channel_a_output,
  input wire logic [CODE_W-1:0] channel_b_output,
  input wire logic power_down,
  input wire logic [1:0] pd_term,
  input wire logic word_applied
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Sync high long enough for any pending word to land
  sequence s_quiet;
    sync_n [*8];
  endsequence
  a_rst_zero: assert property (disable iff (1'b0) rst |=> !word_applied && !power_down
    && channel_a_output == CODE_RST && channel_b_output == CODE_RST) else $error("not cleared");
  a_a_cause: assert property ($changed(channel_a_output) |-> word_applied)
    else $error("channel a moved alone");
  a_b_cause: assert property ($changed(channel_b_output) |-> word_applied)
    else $error("channel b moved alone");
  a_pd_cause: assert property ($changed(power_down) || $changed(pd_term) |-> word_applied)
    else $error("power state moved alone");
  a_pulse_once: assert property (word_applied |=> !word_applied)
    else $error("pulse too long");
  a_quiet_idle: assert property (s_quiet |-> !word_applied)
    else $error("pulse without frame");
  a_term_flag: assert property (power_down == (pd_term != TERM_NONE))
    else $error("power flag and termination differ");
  a_frame_cause: assert property (word_applied |-> !$past(sync_n, 8))
    else $error("pulse not after a frame");
endmodule
bind dds_top dds_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .sync_n(sync_n),
  .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
  .power_down(power_down), .pd_term(pd_term), .word_applied(word_applied));

// File: tb/dds_host.sv
`timescale 1ns/100ps
// Host end of the link; clock idles high between frames
module dds_host (
  output logic link_sclk,
  output logic sync_n,
  output logic din
);
  initial
  begin
    link_sclk = 1;
    sync_n = 1;
    din = 0;
  end
  // Sends n bits MSB first; fewer than 16 aborts the frame
  task automatic send(input logic [15:0] w, input int n);
    sync_n = 0;
    for (int i = 0; i < n; i++)
    begin
      din = w[15-i];
      #24 link_sclk = 0;
      #24 link_sclk = 1;
    end
    #24 sync_n = 1;
    // Released line shows no stale bit
    din = ~din;
  endtask
endmodule

// File: tb/tb_dds_top.sv
`timescale 1ns/100ps
module tb_dds_top;
  import dds_pkg::*;
  logic sys_clk = 0;
  logic rst = 0;
  logic link_sclk, sync_n, din, power_down, word_applied, hit;
  logic [CODE_W-1:0] ch_a, ch_b;
  logic [1:0] pd_term;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #25 sys_clk = ~sys_clk;
  dds_host host (.link_sclk(link_sclk), .sync_n(sync_n), .din(din));
  dds_top dut (.sys_clk(sys_clk), .rst(rst), .link_sclk(link_sclk), .sync_n(sync_n),
    .din(din), .channel_a_output(ch_a), .channel_b_output(ch_b),
    .power_down(power_down), .pd_term(pd_term), .word_applied(word_applied));
  // Cycle ceiling against a hang
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] mk(input logic [1:0] a, m, input logic [7:0] d);
    return {a, m, d, 4'h0};
  endfunction
  // One frame, then watch for the applied pulse
  task automatic xfer(input logic [15:0] w, input int n);
    hit = 0;
    #7 host.send(w, n);
    repeat (10)
    begin
      @(negedge sys_clk);
      if (word_applied === 1'b1)
        hit = 1;
    end
  endtask
  task automatic t_latch_only();
    chk("a", ch_a, CODE_RST);
    chk("pd", 8'(power_down), 8'h00);
    xfer(mk(ADDR_CHAN_A, MODE_WRITE_ONLY, 8'h5a), 16);
    chk("a", ch_a, CODE_RST);
  endtask
  task automatic t_update();
    xfer(mk(ADDR_CHAN_B, MODE_WRITE_UPDATE, 8'hc3), 16);
    chk("hit", 8'(hit), 8'h01);
    chk("b", ch_b, 8'hc3);
    chk("a", ch_a, CODE_RST);
  endtask
  task automatic t_all();
    xfer(mk(ADDR_CHAN_A, MODE_WRITE_ALL, 8'ha5), 16);
    chk("a", ch_a, 8'ha5);
    chk("b", ch_b, 8'ha5);
  endtask
  task automatic t_abort();
    xfer(mk(ADDR_CHAN_B, MODE_WRITE_ALL, 8'h3c), 15);
    chk("hit", 8'(hit), 8'h00);
    chk("b", ch_b, 8'ha5);
  endtask
  task automatic t_power();
    for (int t = 1; t < 4; t++)
    begin
      xfer(mk(2'(t), MODE_POWER, 8'h00), 16);
      chk("pd", 8'(power_down), 8'h01);
      chk("term", 8'(pd_term), 8'(t));
      chk("a", ch_a, 8'ha5);
    end
    xfer(mk(TERM_NONE, MODE_POWER, 8'h00), 16);
    chk("pd", 8'(power_down), 8'h00);
  endtask
  // Mid-run reset clears a powered-down, loaded block, then the link works again
  task automatic t_reset();
    xfer(mk(TERM_OPEN, MODE_POWER, 8'h00), 16);
    chk("pd", 8'(power_down), 8'h01);
    rst = 1;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    chk("a", ch_a, CODE_RST);
    chk("b", ch_b, CODE_RST);
    chk("pd", 8'(power_down), 8'h00);
    chk("term", 8'(pd_term), 8'(TERM_RST));
    xfer(mk(ADDR_CHAN_A, MODE_WRITE_UPDATE, 8'h81), 16);
    chk("hit", 8'(hit), 8'h01);
    chk("a", ch_a, 8'h81);
    chk("b", ch_b, CODE_RST);
  endtask
  initial
  begin
    // A real rising edge also clears the link-side registers
    #1 rst = 1;
    repeat (5) @(negedge sys_clk);
    rst = 0;
    t_latch_only();
    t_update();
    t_all();
    t_abort();
    t_power();
    t_reset();
    give_verdict();
  end
endmodule
